// ===== verilog/ssd_defs.vh
// Constants for the startup strap decoder: register map, strap codes, fields.
// Assumes inclusion by bare name from the design file.
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH
// Register byte offsets
`define SSD_REG_STRAP     12'h000
`define SSD_REG_DECODE    12'h004
`define SSD_REG_GENCTRL   12'h008
`define SSD_REG_PLLCTRL   12'h00c
`define SSD_REG_READY     12'h010
`define SSD_REG_PCIEMAP   12'h014
// Startup codes
`define SSD_CODE_BOOT_LE  4'h0
`define SSD_CODE_PCIE_P10 4'h1
`define SSD_CODE_PCIE_P6  4'h2
`define SSD_CODE_PCIE_P0  4'h3
`define SSD_CODE_PCIE_2X9 4'h4
`define SSD_CODE_PCIE_P9  4'h5
`define SSD_CODE_PCIE_P4  4'h8
`define SSD_CODE_PCIE     4'h9
`define SSD_CODE_MGMT_A0  4'ha
`define SSD_CODE_MGMT_A31 4'hb
`define SSD_CODE_BOOT_BE  4'hc
`define SSD_CODE_NONE     4'hf
// Reference frequency codes and decoded kHz
`define SSD_REF_125       3'h0
`define SSD_REF_156       3'h1
`define SSD_REF_250       3'h2
`define SSD_KHZ_125       20'h1e848
`define SSD_KHZ_156       20'h2625a
`define SSD_KHZ_250       20'h3d090
// Management addresses
`define SSD_MGMT_ADDR_LO  5'h00
`define SSD_MGMT_ADDR_HI  5'h1f
// Host path bits in decode word
`define SSD_HP_PCIE       0
`define SSD_HP_FRAMES     1
`define SSD_HP_MGMT       2
`define SSD_HP_SERIAL     3
// General control field positions
`define SSD_GC_CPU_DIS    0
`define SSD_GC_BOOT_ENA   1
`define SSD_GC_SI_OWNER   2
`define SSD_GC_BE_ENA     3
`define SSD_GC_MGMT_ENA   4
// Port enable bits
`define SSD_PORT_0        0
`define SSD_PORT_4        4
`define SSD_PORT_6        6
`define SSD_PORT_9        9
`define SSD_PORT_10       10
// AXI responses
`define SSD_RESP_OKAY     2'h0
`define SSD_RESP_SLVERR   2'h2
`endif

// ===== verilog/ssd_strap_decoder.v
// Startup strap decoder: latches straps at reset release, decodes startup.
// Assumes straps stable across reset release, and an AXI4-Lite master.
// Function
// RL1 - Strap low: primary PLL clocks core and CPU; secondary off until software
// RL2 - Strap high: secondary PLL enabled, clocks core and CPU
// RL3 - Secondary frequency strap ignored when secondary PLL is disabled
// RL4 - Secondary codes 000, 001, 010 give 125, 156.25, 250 MHz
// RL5 - Code 0000: CPU little endian, flash autoboot, serial slave off
// RL6 - Code 1100: CPU big endian, flash autoboot, serial slave off
// RL7 - Code 0001: PCIe, port 10 SFI, frame port 4 1G, frames, serial
// RL8 - Code 0010: as 0001 but port 6 1G instead of port 10
// RL9 - Code 0011: as 0010 but port 0 instead of port 6
// RL10 - Code 0100: PCIe, ports 10 and 9 SFI, frames, serial slave
// RL11 - Code 0101: PCIe, frame port 9 SFI, frames, serial slave
// RL12 - Code 1000: PCIe, frame port 4 1G with frames, serial slave
// RL13 - Code 1001: PCIe only host path, serial slave enabled
// RL14 - Code 1010: management slave address 0, serial slave enabled
// RL15 - Code 1011: management slave address 31, serial slave enabled
// RL16 - Code 1111: no autoboot, serial slave only
// RL17 - Board straps only defined codes; others reserved
// RL18 - During flash boot the serial interface belongs to booting
// RL19 - PCIe first region maps to CPU subsystem registers
// RL20 - PCIe third region maps to DRAM space
// RL21 - Each enabled host path reaches the whole register set
// RL22 - CPU autoboots or waits for external load and start
// RL23 - Straps latched at reset release and held afterwards
// RL24 - Upper two startup pins driven high once port or endpoint ready; code waits until every enabled PCIe and port path is ready
// RL25 - Latched code sets general control reset value; software may modify
// RL26 - Primary frequency strap forwarded unchanged to primary PLL
`timescale 1ns/1ns
`include "ssd_defs.vh"

module ssd_strap_decoder (
  // Clock and reset
  input  wire        CLK_SYS,
  input  wire        RST,
  // Straps
  input  wire        PLL_SELECT_STRAP,
  input  wire [2:0]  PRIMARY_REFCLK_FREQ_STRAP,
  input  wire [2:0]  SECONDARY_REFCLK_FREQ_STRAP,
  input  wire [3:0]  STARTUP_STRAP,
  // Readiness of enabled paths
  input  wire        PCIE_READY,
  input  wire        PORT_READY,
  // Startup pin upper pair drive
  output reg  [1:0]  STARTUP_HI_OUT,
  output reg  [1:0]  STARTUP_HI_OE_N,
  // Clocking outputs
  output reg         SECONDARY_PLL_ENA,
  output reg         CLK_SRC_SECONDARY,
  output reg  [2:0]  PRIMARY_PLL_FREQ,
  output reg  [2:0]  SECONDARY_PLL_FREQ,
  // Startup outputs
  output reg         CPU_DIS,
  output reg         CPU_BIG_ENDIAN,
  output reg         BOOT_FROM_FLASH,
  output reg         SERIAL_SLAVE_ENA,
  output reg         PCIE_ENA,
  output reg         FRAMES_ENA,
  output reg         MGMT_SLAVE_ENA,
  output reg  [4:0]  MGMT_ADDR,
  output reg  [10:0] PORT_ENA,
  output reg  [10:0] PORT_SFI,
  output reg         STRAP_VALID,
  // AXI4-Lite slave
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);

  // Latched strap state
  reg        latched;
  reg        latched_once;
  reg        sel_q;
  reg [2:0]  pri_q;
  reg [2:0]  sec_q;
  reg [3:0]  code_q;
  // General control and PLL control
  reg [4:0]  gen_ctrl;
  reg        secondary_pll_sw_ena;
  reg        swc_src_sw;
  // AXI write capture
  reg        aw_held;
  reg        w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  // Decoded startup word: {dec_bad, mgmt_addr, sfi, ena, hostpaths}
  reg [4:0]  dec_gc;
  reg [3:0]  dec_hp;
  reg [10:0] dec_ena;
  reg [10:0] dec_sfi;
  reg [4:0]  dec_addr;
  reg        dec_bad;

  // Decode one startup code
  always @* begin
    dec_gc   = 5'h00;
    dec_hp   = 4'h0;
    dec_ena  = 11'h000;
    dec_sfi  = 11'h000;
    dec_addr = `SSD_MGMT_ADDR_LO;
    dec_bad  = 1'b0;
    // Default for host modes: CPU held, no autoboot, serial slave on
    dec_gc[`SSD_GC_CPU_DIS]  = 1'b1;
    dec_hp[`SSD_HP_SERIAL]   = 1'b1;
    case (code_q)
      `SSD_CODE_BOOT_LE, `SSD_CODE_BOOT_BE: begin
        dec_gc[`SSD_GC_CPU_DIS]  = 1'b0;                          // [RL5] [RL6] [RL22]
        dec_gc[`SSD_GC_BOOT_ENA] = 1'b1;
        dec_gc[`SSD_GC_SI_OWNER] = 1'b1;                          // [RL18]
        dec_gc[`SSD_GC_BE_ENA]   = (code_q == `SSD_CODE_BOOT_BE); // [RL6]
        dec_hp[`SSD_HP_SERIAL]   = 1'b0;                          // [RL18]
      end
      `SSD_CODE_PCIE_P10: begin
        dec_hp[`SSD_HP_PCIE]       = 1'b1;                        // [RL7]
        dec_hp[`SSD_HP_FRAMES]     = 1'b1;
        dec_ena[`SSD_PORT_10]      = 1'b1;
        dec_sfi[`SSD_PORT_10]      = 1'b1;
        dec_ena[`SSD_PORT_4]       = 1'b1;
      end
      `SSD_CODE_PCIE_P6: begin
        dec_hp[`SSD_HP_PCIE]       = 1'b1;                        // [RL8]
        dec_hp[`SSD_HP_FRAMES]     = 1'b1;
        dec_ena[`SSD_PORT_6]       = 1'b1;
        dec_ena[`SSD_PORT_4]       = 1'b1;
      end
      `SSD_CODE_PCIE_P0: begin
        dec_hp[`SSD_HP_PCIE]       = 1'b1;                        // [RL9]
        dec_hp[`SSD_HP_FRAMES]     = 1'b1;
        dec_ena[`SSD_PORT_0]       = 1'b1;
        dec_ena[`SSD_PORT_4]       = 1'b1;
      end
      `SSD_CODE_PCIE_2X9: begin
        dec_hp[`SSD_HP_PCIE]       = 1'b1;                        // [RL10]
        dec_hp[`SSD_HP_FRAMES]     = 1'b1;
        dec_ena[`SSD_PORT_10]      = 1'b1;
        dec_sfi[`SSD_PORT_10]      = 1'b1;
        dec_ena[`SSD_PORT_9]       = 1'b1;
        dec_sfi[`SSD_PORT_9]       = 1'b1;
      end
      `SSD_CODE_PCIE_P9: begin
        dec_hp[`SSD_HP_PCIE]       = 1'b1;                        // [RL11]
        dec_hp[`SSD_HP_FRAMES]     = 1'b1;
        dec_ena[`SSD_PORT_9]       = 1'b1;
        dec_sfi[`SSD_PORT_9]       = 1'b1;
      end
      `SSD_CODE_PCIE_P4: begin
        dec_hp[`SSD_HP_PCIE]       = 1'b1;                        // [RL12]
        dec_hp[`SSD_HP_FRAMES]     = 1'b1;
        dec_ena[`SSD_PORT_4]       = 1'b1;
      end
      `SSD_CODE_PCIE: begin
        dec_hp[`SSD_HP_PCIE]       = 1'b1;                        // [RL13]
      end
      `SSD_CODE_MGMT_A0, `SSD_CODE_MGMT_A31: begin
        dec_hp[`SSD_HP_MGMT]       = 1'b1;                        // [RL14] [RL15]
        dec_gc[`SSD_GC_MGMT_ENA]   = 1'b1;
        dec_addr = (code_q == `SSD_CODE_MGMT_A31) ? `SSD_MGMT_ADDR_HI
                                                  : `SSD_MGMT_ADDR_LO;
      end
      `SSD_CODE_NONE: begin
        dec_hp[`SSD_HP_SERIAL]     = 1'b1;                        // [RL16]
      end
      default: begin
        dec_bad = 1'b1;                                           // [RL17]
      end
    endcase
  end

  // Secondary frequency decode into kHz for status readback
  function [19:0] ssd_ref_khz;
    input [2:0] f;
    begin
      case (f)
        `SSD_REF_125: ssd_ref_khz = `SSD_KHZ_125;                 // [RL4]
        `SSD_REF_156: ssd_ref_khz = `SSD_KHZ_156;
        `SSD_REF_250: ssd_ref_khz = `SSD_KHZ_250;
        default:      ssd_ref_khz = 20'h00000;
      endcase
    end
  endfunction

  wire secondary_pll_on = sel_q | secondary_pll_sw_ena;
  wire any_path_port = dec_hp[`SSD_HP_PCIE] | (|dec_ena);
  wire path_ready = (dec_hp[`SSD_HP_PCIE] ? PCIE_READY : 1'b1) &
                    ((|dec_ena) ? PORT_READY : 1'b1);
  // Code loads general control once; outputs see it in that same cycle
  wire       gc_load = latched && !latched_once;
  wire [4:0] gc_now  = gc_load ? dec_gc : gen_ctrl;

  // Strap latch on the first clock after reset release
  always @(posedge CLK_SYS) begin
    if (RST) begin
      latched <= 1'b0;
      sel_q   <= 1'b0;
      pri_q   <= 3'h0;
      sec_q   <= 3'h0;
      code_q  <= 4'h0;
    end else if (!latched) begin
      latched <= 1'b1;                                            // [RL23]
      sel_q   <= PLL_SELECT_STRAP;
      pri_q   <= PRIMARY_REFCLK_FREQ_STRAP;                       // [RL26]
      sec_q   <= SECONDARY_REFCLK_FREQ_STRAP;
      code_q  <= STARTUP_STRAP;
    end
  end

  // Registered outputs from latched and decoded state
  always @(posedge CLK_SYS) begin
    if (RST || !latched) begin
      SECONDARY_PLL_ENA  <= 1'b0;
      CLK_SRC_SECONDARY  <= 1'b0;
      PRIMARY_PLL_FREQ   <= 3'h0;
      SECONDARY_PLL_FREQ <= 3'h0;
      CPU_DIS            <= 1'b1;
      CPU_BIG_ENDIAN     <= 1'b0;
      BOOT_FROM_FLASH    <= 1'b0;
      SERIAL_SLAVE_ENA   <= 1'b0;
      PCIE_ENA           <= 1'b0;
      FRAMES_ENA         <= 1'b0;
      MGMT_SLAVE_ENA     <= 1'b0;
      MGMT_ADDR          <= 5'h00;
      PORT_ENA           <= 11'h000;
      PORT_SFI           <= 11'h000;
      STARTUP_HI_OUT     <= 2'h0;
      STARTUP_HI_OE_N    <= 2'h3;
      STRAP_VALID        <= 1'b0;
    end else begin
      SECONDARY_PLL_ENA  <= secondary_pll_on;                              // [RL1] [RL2]
      CLK_SRC_SECONDARY  <= sel_q ? !swc_src_sw : swc_src_sw;     // [RL1] [RL2]
      PRIMARY_PLL_FREQ   <= pri_q;                                // [RL26]
      SECONDARY_PLL_FREQ <= secondary_pll_on ? sec_q : 3'h0;               // [RL3]
      CPU_DIS            <= gc_now[`SSD_GC_CPU_DIS];              // [RL22]
      CPU_BIG_ENDIAN     <= gc_now[`SSD_GC_BE_ENA];
      BOOT_FROM_FLASH    <= gc_now[`SSD_GC_BOOT_ENA];
      SERIAL_SLAVE_ENA   <= !gc_now[`SSD_GC_SI_OWNER];            // [RL18] [RL21]
      PCIE_ENA           <= dec_hp[`SSD_HP_PCIE];                 // [RL21]
      FRAMES_ENA         <= dec_hp[`SSD_HP_FRAMES];
      MGMT_SLAVE_ENA     <= gc_now[`SSD_GC_MGMT_ENA];
      MGMT_ADDR          <= dec_addr;
      PORT_ENA           <= dec_ena;
      PORT_SFI           <= dec_sfi;
      STRAP_VALID        <= !dec_bad;
      STARTUP_HI_OUT     <= 2'h3;
      STARTUP_HI_OE_N    <= (any_path_port && path_ready) ? 2'h0 : 2'h3; // [RL24]
    end
  end

  // Software control registers; general control reloads from the code
  always @(posedge CLK_SYS) begin
    if (RST) begin
      gen_ctrl    <= 5'h01;
      secondary_pll_sw_ena <= 1'b0;
      swc_src_sw  <= 1'b0;
    end else if (gc_load) begin
      gen_ctrl    <= dec_gc;                                      // [RL25]
    end else if (aw_held && w_held && !S_AXI_BVALID) begin
      if (aw_addr == `SSD_REG_GENCTRL && w_strb[0])
        gen_ctrl <= w_data[4:0];                                  // [RL25]
      if (aw_addr == `SSD_REG_PLLCTRL && w_strb[0]) begin
        secondary_pll_sw_ena <= w_data[0];                                 // [RL1]
        swc_src_sw  <= w_data[1];
      end
    end
  end

  // One-shot marker so the code loads general control exactly once
  always @(posedge CLK_SYS) begin
    if (RST)
      latched_once <= 1'b0;
    else if (latched)
      latched_once <= 1'b1;
  end

  // AXI write channel: address and data in either order
  always @(posedge CLK_SYS) begin
    if (RST) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `SSD_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (aw_held && w_held && !S_AXI_BVALID) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr == `SSD_REG_GENCTRL || aw_addr == `SSD_REG_PLLCTRL)
                        ? `SSD_RESP_OKAY : `SSD_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // AXI read channel
  always @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `SSD_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= `SSD_RESP_OKAY;
        case (S_AXI_ARADDR)
          `SSD_REG_STRAP:
            S_AXI_RDATA <= {20'h00000, code_q, sec_q, pri_q, sel_q, latched};
          `SSD_REG_DECODE:
            S_AXI_RDATA <= {dec_bad, dec_addr, dec_sfi, dec_ena, dec_hp};
          `SSD_REG_GENCTRL:
            S_AXI_RDATA <= {27'h0, gen_ctrl};
          `SSD_REG_PLLCTRL:
            S_AXI_RDATA <= {30'h0, swc_src_sw, secondary_pll_sw_ena};
          `SSD_REG_READY:
            S_AXI_RDATA <= {ssd_ref_khz(secondary_pll_on ? sec_q : 3'h7), 10'h000,
                            ~STARTUP_HI_OE_N};                    // [RL3] [RL4]
          `SSD_REG_PCIEMAP:
            S_AXI_RDATA <= 32'h00000005;                          // [RL19] [RL20]
          default: begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `SSD_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

// ===== testbench/ssd_strap_board.sv
// Strap resistor model: strap levels in reset, pins reused afterwards.
// Assumes cfg is set before reset is raised.
`timescale 1ns/1ns
module ssd_strap_board (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Strap levels and pins
  input  wire [10:0] cfg,
  output reg  [10:0] pins
);
  reg                settled;
  initial pins = 11'h000;
  initial settled = 1'b0;
  // Levels kept through the latch edge, then pins toggle every cycle
  always @(posedge clk) begin
    if (rst) begin
      pins    <= cfg;
      settled <= 1'b0;
    end else if (!settled) begin
      settled <= 1'b1;
    end else begin
      pins <= ~pins;
    end
  end
endmodule

// ===== testbench/ssd_strap_assertions.sv
// Checker on decoder ports: latch timing, clock and startup decode.
// Assumes one clock domain with synchronous reset.
`timescale 1ns/1ns
module ssd_strap_checker (
  // Clock and reset
  input wire        CLK_SYS,
  input wire        RST,
  // Straps and readiness
  input wire        PLL_SELECT_STRAP,
  input wire [2:0]  PRIMARY_REFCLK_FREQ_STRAP,
  input wire [3:0]  STARTUP_STRAP,
  input wire        PCIE_READY,
  input wire        PORT_READY,
  // Decoded outputs
  input wire [1:0]  STARTUP_HI_OE_N,
  input wire        SECONDARY_PLL_ENA,
  input wire        CLK_SRC_SECONDARY,
  input wire [2:0]  PRIMARY_PLL_FREQ,
  input wire [2:0]  SECONDARY_PLL_FREQ,
  input wire        CPU_DIS,
  input wire        CPU_BIG_ENDIAN,
  input wire        BOOT_FROM_FLASH,
  input wire        SERIAL_SLAVE_ENA,
  input wire        PCIE_ENA,
  input wire [10:0] PORT_ENA
);
  // Single domain
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_ena;
    $fell(RST) |-> ##2 SECONDARY_PLL_ENA == $past(PLL_SELECT_STRAP, 2);
  endproperty
  a_ena: assert property (p_ena)
    else $error("secondary_pll enable wrong");
  property p_src;
    $fell(RST) |-> ##2 CLK_SRC_SECONDARY == $past(PLL_SELECT_STRAP, 2);
  endproperty
  a_src: assert property (p_src)
    else $error("clock source wrong");
  property p_pri;
    $fell(RST) |-> ##2 PRIMARY_PLL_FREQ == $past(PRIMARY_REFCLK_FREQ_STRAP, 2);
  endproperty
  a_pri: assert property (p_pri)
    else $error("pll freq wrong");
  property p_off;
    !SECONDARY_PLL_ENA |-> SECONDARY_PLL_FREQ == 3'h0;
  endproperty
  a_off: assert property (p_off)
    else $error("secondary_pll freq not ignored");
  property p_hold;
    !$past(RST) && !$past(RST, 2) && !$past(RST, 3) |-> $stable(PRIMARY_PLL_FREQ) && $stable(PORT_ENA);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched value moved");
  property p_le;
    $fell(RST) && STARTUP_STRAP == 4'h0 |-> ##2 !CPU_DIS && !CPU_BIG_ENDIAN && BOOT_FROM_FLASH && !SERIAL_SLAVE_ENA;
  endproperty
  a_le: assert property (p_le)
    else $error("little endian boot wrong");
  property p_be;
    $fell(RST) && STARTUP_STRAP == 4'hc |-> ##2 !CPU_DIS && CPU_BIG_ENDIAN && BOOT_FROM_FLASH && !SERIAL_SLAVE_ENA;
  endproperty
  a_be: assert property (p_be)
    else $error("big endian boot wrong");
  property p_drive;
    PCIE_ENA && PCIE_READY && PORT_READY |-> ##[1:2] STARTUP_HI_OE_N == 2'b00;
  endproperty
  a_drive: assert property (p_drive)
    else $error("pins not driven");
  property p_idle;
    !PCIE_ENA && PORT_ENA == 11'h000 |-> STARTUP_HI_OE_N == 2'b11;
  endproperty
  a_idle: assert property (p_idle)
    else $error("pins driven without path");
endmodule
bind ssd_strap_decoder ssd_strap_checker ssd_strap_checker_inst (.*);

// ===== testbench/tb.sv
// Testbench for the strap decoder: strap model plus an AXI4-Lite master.
// Assumes straps latched at reset release and registered AXI answers.
`timescale 1ns/1ns
`include "ssd_defs.vh"
module tb;
  // Inputs driven here
  reg         CLK_SYS, RST, PCIE_READY, PORT_READY;
  reg  [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  reg  [31:0] S_AXI_WDATA;
  reg  [3:0]  S_AXI_WSTRB;
  reg         S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  reg  [10:0] cfg;
  // Strap pins and design outputs
  wire        PLL_SELECT_STRAP;
  wire [2:0]  PRIMARY_REFCLK_FREQ_STRAP, SECONDARY_REFCLK_FREQ_STRAP;
  wire [3:0]  STARTUP_STRAP;
  wire [1:0]  STARTUP_HI_OUT, STARTUP_HI_OE_N, S_AXI_BRESP, S_AXI_RRESP;
  wire        SECONDARY_PLL_ENA, CLK_SRC_SECONDARY, CPU_DIS, CPU_BIG_ENDIAN, BOOT_FROM_FLASH;
  wire        SERIAL_SLAVE_ENA, PCIE_ENA, FRAMES_ENA, MGMT_SLAVE_ENA, STRAP_VALID;
  wire [2:0]  PRIMARY_PLL_FREQ, SECONDARY_PLL_FREQ;
  wire [4:0]  MGMT_ADDR;
  wire [10:0] PORT_ENA, PORT_SFI;
  wire        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire [31:0] S_AXI_RDATA;
  wire [33:0] dec_seen = {CPU_DIS, CPU_BIG_ENDIAN, BOOT_FROM_FLASH, SERIAL_SLAVE_ENA, PCIE_ENA,
                          FRAMES_ENA, MGMT_SLAVE_ENA, MGMT_ADDR, PORT_ENA, PORT_SFI};
  integer     error_cnt, n_tests, cyc;
  reg  [31:0] rd;
  reg  [1:0]  rsp;
  localparam [47:0] CODES = 48'h0123_4589_abcf;

  ssd_strap_board ssd_strap_board_inst (.clk(CLK_SYS), .rst(RST), .cfg(cfg),
    .pins({PLL_SELECT_STRAP, PRIMARY_REFCLK_FREQ_STRAP, SECONDARY_REFCLK_FREQ_STRAP, STARTUP_STRAP}));
  ssd_strap_decoder ssd_strap_decoder_inst (.*);

  // Clock and hang limit
  always #10 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end

  // Expected decode word per startup code
  function [33:0] exp_dec(input [3:0] c);
    reg [10:0] e, s;
    reg        f;
    begin
      e = 11'h000;
      s = 11'h000;
      f = 1'b1;
      case (c)
        4'h1: begin e = 11'h410; s = 11'h400; end
        4'h2: e = 11'h050;
        4'h3: e = 11'h011;
        4'h4: begin e = 11'h600; s = 11'h600; end
        4'h5: begin e = 11'h200; s = 11'h200; end
        4'h8: e = 11'h010;
        default: f = 1'b0;
      endcase
      if (c == 4'h0 || c == 4'hc)
        exp_dec = {1'b0, c[3], 2'b10, 30'h0};
      else
        exp_dec = {4'b1001, c < 4'ha, f, c == 4'ha || c == 4'hb, {5{c == 4'hb}}, e, s};
    end
  endfunction

  task chk(input string nm, input [63:0] exp, input [63:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task do_reset(input [10:0] c);
    begin
      @(posedge CLK_SYS);
      cfg <= c;
      RST <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
    end
  endtask

  // Waits for the answer; only the hang limit ends a stuck transfer
  task axi_wr(input [11:0] a, input [31:0] d, output [1:0] r);
    begin
      @(posedge CLK_SYS);
      S_AXI_AWADDR  <= a;
      S_AXI_WDATA   <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID  <= 1'b1;
      S_AXI_BREADY  <= 1'b1;
      @(posedge CLK_SYS);
      while (S_AXI_BVALID !== 1'b1) begin
        if (S_AXI_AWREADY === 1'b1)
          S_AXI_AWVALID <= 1'b0;
        if (S_AXI_WREADY === 1'b1)
          S_AXI_WVALID <= 1'b0;
        @(posedge CLK_SYS);
      end
      r = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
    end
  endtask

  task axi_rd(input [11:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge CLK_SYS);
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY  <= 1'b1;
      @(posedge CLK_SYS);
      while (S_AXI_RVALID !== 1'b1) begin
        if (S_AXI_ARREADY === 1'b1)
          S_AXI_ARVALID <= 1'b0;
        @(posedge CLK_SYS);
      end
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
    end
  endtask

  // Every defined startup code, pins toggling after the latch
  task t_codes;
    integer i;
    reg [3:0] c;
    begin
      for (i = 0; i < 12; i = i + 1) begin
        c = CODES[47 - 4 * i -: 4];
        do_reset({7'h00, c});
        chk("decode", exp_dec(c), dec_seen);
        chk("valid", 1'b1, STRAP_VALID);
      end
      $display("test codes done");
    end
  endtask

  // PLL select off, then each secondary frequency code
  task t_pll;
    integer k;
    reg [2:0] s;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        s = (k == 0) ? 3'h2 : k - 1;
        do_reset({k != 0, k[2:0] + 3'h3, s, 4'hf});
        chk("secondary_pll ena", k != 0, SECONDARY_PLL_ENA);
        chk("clk src", k != 0, CLK_SRC_SECONDARY);
        chk("secondary_pll freq", (k != 0) ? s : 3'h0, SECONDARY_PLL_FREQ);
        chk("pll freq", k[2:0] + 3'h3, PRIMARY_PLL_FREQ);
        axi_rd(`SSD_REG_READY, rd, rsp);
        chk("ref khz", (k == 0) ? 0 : (k == 1) ? 125000 : (k == 2) ? 156250 : 250000, rd[31:12]);
      end
      $display("test pll done");
    end
  endtask

  // Pin drive once endpoint and port are ready
  task t_ready;
    begin
      do_reset({7'h00, 4'h1});
      chk("oe idle", 2'b11, STARTUP_HI_OE_N);
      PCIE_READY <= 1'b1;
      PORT_READY <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      chk("oe ready", 2'b00, STARTUP_HI_OE_N);
      chk("hi out", 2'b11, STARTUP_HI_OUT);
      axi_rd(`SSD_REG_READY, rd, rsp);
      chk("pins reg", 2'b11, rd[1:0]);
      axi_wr(`SSD_REG_PLLCTRL, 32'h1, rsp);
      @(posedge CLK_SYS);
      chk("sw secondary_pll", 4'h2, {rsp, SECONDARY_PLL_ENA, CLK_SRC_SECONDARY});
      do_reset({7'h00, 4'ha});
      chk("oe mgmt", 2'b11, STARTUP_HI_OE_N);
      PCIE_READY <= 1'b0;
      PORT_READY <= 1'b0;
      $display("test ready done");
    end
  endtask

  // General control reset value, software change, bus refusals
  task t_genctrl;
    begin
      do_reset({1'b1, 3'h5, 3'h1, 4'h0});
      axi_rd(`SSD_REG_STRAP, rd, rsp);
      chk("strap reg", 32'h37, rd);
      axi_rd(`SSD_REG_GENCTRL, rd, rsp);
      chk("genctrl rst", 32'h6, rd);
      axi_wr(`SSD_REG_GENCTRL, 32'h11, rsp);
      chk("wr resp", `SSD_RESP_OKAY, rsp);
      axi_rd(`SSD_REG_GENCTRL, rd, rsp);
      chk("genctrl rd", 32'h11, rd);
      chk("cpu off mgmt on serial on", 3'h7, {CPU_DIS, MGMT_SLAVE_ENA, SERIAL_SLAVE_ENA});
      axi_wr(`SSD_REG_STRAP, 32'h0, rsp);
      chk("ro resp", `SSD_RESP_SLVERR, rsp);
      axi_rd(`SSD_REG_STRAP, rd, rsp);
      chk("strap kept", 32'h37, rd);
      axi_rd(`SSD_REG_PCIEMAP, rd, rsp);
      chk("pcie map", 32'h5, rd);
      axi_rd(12'hffc, rd, rsp);
      chk("unmapped", {`SSD_RESP_SLVERR, 32'h0}, {rsp, rd});
      $display("test genctrl done");
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    {CLK_SYS, PCIE_READY, PORT_READY, S_AXI_AWVALID, S_AXI_WVALID} = 5'h00;
    {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 3'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 56'h0;
    S_AXI_WSTRB = 4'hf;
    RST = 1'b1;
    cfg = 11'h000;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    t_codes;
    t_pll;
    t_ready;
    t_genctrl;
    stop_test;
  end
endmodule
